// ### common/nna_defines.svh
`ifndef NNA_DEFINES_SVH
`define NNA_DEFINES_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_CYC 8'h08
`define REG_CMDS 8'h0C
`define REG_DENSE 8'h10
`define REG_GPO 8'h14

// Field positions
`define CTRL_RUN 0
`define STAT_IDLE 0
`define STAT_REFILL 1
`define STAT_ACT_LSB 8
`define ACT_CONV 0
`define ACT_DENSE 1
`define ACT_USED_MASK 8'h03

// Command opcodes
`define OP_NOP 4'h0
`define OP_FINISH 4'h1
`define OP_CONV 4'h2
`define OP_DENSE 4'h3
`define OP_RESULT 4'h4
`define OP_DEBUG 4'h5
`define OP_GPO 4'h6

// Reset values and responses
`define IDLE_RESET 1'b1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ONE32 32'h00000001
`define ONE16 16'h0001
`define PTR_PAD 4'h0

`endif

// ### common/nna_pkg.sv
package nna_pkg;

    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_FETCH = 8'h02,
        S_CONV  = 8'h04,
        S_DWAIT = 8'h08,
        S_DENSE = 8'h10,
        S_TWAIT = 8'h20,
        S_EMIT  = 8'h40,
        S_GPO   = 8'h80
    } state_t;

    // Command word layout
    typedef struct packed {
        logic [3:0] op;
        logic [11:0] arg;
        logic [15:0] len;
    } cmd_t;

endpackage

// ### core/nna_host_if.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "nna_defines.svh"
// Summary of operation
// R1 - Synchronous active-low reset puts every port and register at its default; the input memory is not reset.
// R2 - Controller holds run request high until idle flag falls, then releases.
// R3 - Idle flag is high after reset and when idle, low while executing.
// R4 - Run request seen while idle starts execution and drops the idle flag.
// R5 - Finish command raises idle flag and returns to idle awaiting next run.
// R6 - Activity bit0 non-dense engines, bit1 dense engine, bits 2 to 7 zero.
// R7 - Run cycle counter counts busy cycles, cleared when run is accepted.
// R8 - Command counter counts processed commands, cleared when run is accepted.
// R9 - Dense cycle counter counts dense-layer cycles, cleared on run.
// R10 - Firmware output word is loaded by a command.
// R11 - Input memory written only when strobe is high; otherwise address and data ignored.
// R12 - Input writes while busy are discarded.
// R13 - Input writes in any order; last value written to an address stays.
// R14 - Refill request low asks for queue flush and reload; high is normal.
// R15 - After run, refill request rises and command reads proceed.
// R16 - Command word captured only when queue not empty and read requested.
// R17 - Queue keeps its output word while not empty is false and no read.
// R18 - While queue not low, it supplies dense weights one word per two cycles.
// R19 - Result words are 16 bits, flagged by result valid, no backpressure.
// R20 - Debug words share the result bus, flagged by trace valid.
// R21 - Device waits for trace ready before each debug burst.
// R22 - Controller ties trace ready high when debug output is unused.
// R23 - Reset of one cycle gives idle high, the AXI AWREADY, WREADY and ARREADY high, and all other outputs low next cycle.
// R24 - Controller places 8-bit input bytes in the low half, upper half zero.
// R25 - Result valid and trace valid are never high together.
module nna_host_if #(
    parameter int MEM_AW = 16,
    parameter int AXI_AW = 8
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic RUN_REQUEST,
    output logic IDLE_FLAG,
    output logic [7:0] ACTIVITY_FLAGS,
    output logic [31:0] RUN_CYCLE_COUNT,
    output logic [31:0] COMMAND_COUNT,
    output logic [31:0] DENSE_CYCLE_COUNT,
    output logic [31:0] FIRMWARE_OUTPUT_WORD,
    input wire logic INPUT_WRITE_STROBE,
    input wire logic [15:0] INPUT_ADDR,
    input wire logic [15:0] INPUT_DATA,
    output logic QUEUE_REFILL_REQUEST,
    input wire logic QUEUE_EMPTY_FLAG,
    input wire logic QUEUE_LOW_FLAG,
    output logic QUEUE_READ_REQUEST,
    input wire logic [31:0] QUEUE_WORD,
    output logic RESULT_VALID,
    output logic TRACE_VALID,
    output logic [15:0] RESULT_WORD,
    input wire logic TRACE_READY,
    input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // Input memory; not reset, software loads it before each run
    logic [15:0] mem [2**MEM_AW];
    nna_pkg::state_t st_q, st_d;
    nna_pkg::cmd_t cmd;
    logic idle_q, idle_d;
    logic refill_q, refill_d;
    logic [7:0] act_q, act_d;
    logic [31:0] cyc_q, cyc_d;
    logic [31:0] cmds_q, cmds_d;
    logic [31:0] dcyc_q, dcyc_d;
    logic [31:0] gpo_q, gpo_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] ptr_q, ptr_d;
    logic phase_q, phase_d;
    logic trc_q, trc_d;
    logic rv_q, rv_d;
    logic tv_q, tv_d;
    logic [15:0] dout_q, dout_d;
    logic ctrl_q, ctrl_d;
    logic run, rd, take, mem_we;
    assign cmd = nna_pkg::cmd_t'(QUEUE_WORD);
    // Pin and software run bit are both levels
    assign run = RUN_REQUEST | ctrl_q;
    assign rd = (st_q == nna_pkg::S_FETCH) || (st_q == nna_pkg::S_GPO)
        || ((st_q == nna_pkg::S_DENSE) && phase_q);
    assign take = rd && !QUEUE_EMPTY_FLAG; // R16
    // Busy writes are dropped so the engine never sees a half-updated blob
    assign mem_we = INPUT_WRITE_STROBE && idle_q; // R11 R12
    always_ff @(posedge REF_CLK) begin
        if (mem_we) begin
            mem[INPUT_ADDR[MEM_AW-1:0]] <= INPUT_DATA; // R13
        end
    end
    always_comb begin
        st_d = st_q;
        idle_d = idle_q;
        refill_d = refill_q;
        cyc_d = idle_q ? cyc_q : cyc_q + `ONE32; // R7
        cmds_d = cmds_q;
        dcyc_d = dcyc_q;
        gpo_d = gpo_q;
        cnt_d = cnt_q;
        ptr_d = ptr_q;
        phase_d = phase_q;
        trc_d = trc_q;
        rv_d = 1'b0;
        tv_d = 1'b0;
        dout_d = dout_q;
        unique case (st_q)
            nna_pkg::S_IDLE: begin
                if (run) begin
                    st_d = nna_pkg::S_FETCH; // R4
                    idle_d = 1'b0; // R3
                    refill_d = 1'b1; // R14 R15
                    cyc_d = '0; // R7
                    cmds_d = '0; // R8
                    dcyc_d = '0; // R9
                end
            end
            nna_pkg::S_FETCH: begin
                if (take) begin
                    cmds_d = cmds_q + `ONE32; // R8
                    cnt_d = cmd.len;
                    ptr_d = {cmd.arg, `PTR_PAD};
                    trc_d = (cmd.op == `OP_DEBUG);
                    case (cmd.op)
                        `OP_FINISH: begin
                            st_d = nna_pkg::S_IDLE; // R5
                            idle_d = 1'b1; // R5
                        end
                        `OP_CONV: begin
                            if (cmd.len != '0) begin
                                st_d = nna_pkg::S_CONV;
                            end
                        end
                        `OP_DENSE: begin
                            if (cmd.len != '0) begin
                                st_d = nna_pkg::S_DWAIT;
                            end
                        end
                        `OP_RESULT: begin
                            if (cmd.len != '0) begin
                                st_d = nna_pkg::S_EMIT;
                            end
                        end
                        `OP_DEBUG: begin
                            if (cmd.len != '0) begin
                                st_d = nna_pkg::S_TWAIT;
                            end
                        end
                        `OP_GPO: begin
                            st_d = nna_pkg::S_GPO;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            nna_pkg::S_CONV: begin
                cnt_d = cnt_q - `ONE16;
                if (cnt_q == `ONE16) begin
                    st_d = nna_pkg::S_FETCH;
                end
            end
            nna_pkg::S_DWAIT: begin
                // Weights must then stream without gaps, so wait until the queue low flag drops
                if (!QUEUE_LOW_FLAG) begin
                    st_d = nna_pkg::S_DENSE;
                    phase_d = 1'b0;
                end
            end
            nna_pkg::S_DENSE: begin
                dcyc_d = dcyc_q + `ONE32; // R9
                phase_d = !take;
                if (take) begin
                    cnt_d = cnt_q - `ONE16;
                    if (cnt_q == `ONE16) begin
                        st_d = nna_pkg::S_FETCH;
                    end
                end
            end
            nna_pkg::S_TWAIT: begin
                if (TRACE_READY) begin
                    st_d = nna_pkg::S_EMIT; // R21
                end
            end
            nna_pkg::S_EMIT: begin
                dout_d = mem[ptr_q[MEM_AW-1:0]]; // R19 R20
                rv_d = !trc_q; // R25
                tv_d = trc_q; // R20 R25
                ptr_d = ptr_q + `ONE16;
                cnt_d = cnt_q - `ONE16;
                if (cnt_q == `ONE16) begin
                    st_d = nna_pkg::S_FETCH;
                end
            end
            nna_pkg::S_GPO: begin
                if (take) begin
                    gpo_d = QUEUE_WORD; // R10
                    st_d = nna_pkg::S_FETCH;
                end
            end
        endcase
        act_d = '0;
        act_d[`ACT_CONV] = (st_d == nna_pkg::S_CONV); // R6
        act_d[`ACT_DENSE] = (st_d == nna_pkg::S_DENSE); // R6
    end
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            st_q <= nna_pkg::S_IDLE; // R1 R23
            idle_q <= `IDLE_RESET;
            refill_q <= 1'b0;
            act_q <= '0;
            cyc_q <= '0;
            cmds_q <= '0;
            dcyc_q <= '0;
            gpo_q <= '0;
            cnt_q <= '0;
            ptr_q <= '0;
            phase_q <= 1'b0;
            trc_q <= 1'b0;
            rv_q <= 1'b0;
            tv_q <= 1'b0;
            dout_q <= '0;
        end else begin
            st_q <= st_d;
            idle_q <= idle_d;
            refill_q <= refill_d;
            act_q <= act_d;
            cyc_q <= cyc_d;
            cmds_q <= cmds_d;
            dcyc_q <= dcyc_d;
            gpo_q <= gpo_d;
            cnt_q <= cnt_d;
            ptr_q <= ptr_d;
            phase_q <= phase_d;
            trc_q <= trc_d;
            rv_q <= rv_d;
            tv_q <= tv_d;
            dout_q <= dout_d;
        end
    end
    assign IDLE_FLAG = idle_q;
    assign ACTIVITY_FLAGS = act_q;
    assign RUN_CYCLE_COUNT = cyc_q;
    assign COMMAND_COUNT = cmds_q;
    assign DENSE_CYCLE_COUNT = dcyc_q;
    assign FIRMWARE_OUTPUT_WORD = gpo_q;
    assign QUEUE_REFILL_REQUEST = refill_q;
    assign QUEUE_READ_REQUEST = rd;
    assign RESULT_VALID = rv_q;
    assign TRACE_VALID = tv_q;
    assign RESULT_WORD = dout_q;
    // AXI4-Lite slave
    logic aw_q, aw_d;
    logic [AXI_AW-1:0] awa_q, awa_d;
    logic wh_q, wh_d;
    logic [31:0] wd_q, wd_d;
    logic ws_q, ws_d;
    logic bv_q, bv_d;
    logic [1:0] br_q, br_d;
    logic arv_q, arv_d;
    logic [31:0] rdat_q, rdat_d;
    logic [1:0] rr_q, rr_d;
    assign S_AXI_AWREADY = !aw_q && !bv_q;
    assign S_AXI_WREADY = !wh_q && !bv_q;
    assign S_AXI_ARREADY = !arv_q;
    always_comb begin
        aw_d = aw_q;
        awa_d = awa_q;
        wh_d = wh_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q && !S_AXI_BREADY;
        br_d = br_q;
        ctrl_d = ctrl_q;
        arv_d = arv_q && !S_AXI_RREADY;
        rdat_d = rdat_q;
        rr_d = rr_q;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_d = 1'b1;
            awa_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            wh_d = 1'b1;
            wd_d = S_AXI_WDATA;
            ws_d = S_AXI_WSTRB[0];
        end
        if (aw_q && wh_q) begin
            aw_d = 1'b0;
            wh_d = 1'b0;
            bv_d = 1'b1;
            br_d = (awa_q == `REG_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
            if ((awa_q == `REG_CTRL) && ws_q) begin
                ctrl_d = wd_q[`CTRL_RUN];
            end
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            arv_d = 1'b1;
            rdat_d = '0;
            rr_d = `RESP_OKAY;
            case (S_AXI_ARADDR)
                `REG_CTRL: rdat_d[`CTRL_RUN] = ctrl_q;
                `REG_STAT: begin
                    rdat_d[`STAT_IDLE] = idle_q;
                    rdat_d[`STAT_REFILL] = refill_q;
                    rdat_d[`STAT_ACT_LSB +: 8] = act_q;
                end
                `REG_CYC: rdat_d = cyc_q;
                `REG_CMDS: rdat_d = cmds_q;
                `REG_DENSE: rdat_d = dcyc_q;
                `REG_GPO: rdat_d = gpo_q;
                default: rr_d = `RESP_SLVERR;
            endcase
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            aw_q <= 1'b0;
            awa_q <= '0;
            wh_q <= 1'b0;
            wd_q <= '0;
            ws_q <= 1'b0;
            bv_q <= 1'b0;
            br_q <= `RESP_OKAY;
            ctrl_q <= 1'b0;
            arv_q <= 1'b0;
            rdat_q <= '0;
            rr_q <= `RESP_OKAY;
        end else begin
            aw_q <= aw_d;
            awa_q <= awa_d;
            wh_q <= wh_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            ctrl_q <= ctrl_d;
            arv_q <= arv_d;
            rdat_q <= rdat_d;
            rr_q <= rr_d;
        end
    end
    assign S_AXI_BVALID = bv_q;
    assign S_AXI_BRESP = br_q;
    assign S_AXI_RVALID = arv_q;
    assign S_AXI_RDATA = rdat_q;
    assign S_AXI_RRESP = rr_q;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    sequence s_start;
        idle_q && run;
    endsequence
    sequence s_finish;
        (st_q == nna_pkg::S_FETCH) && take && (cmd.op == `OP_FINISH);
    endsequence
    AST_RESET: assert property (@(posedge REF_CLK) disable iff (1'b0) // R23
        !RSTN |=> IDLE_FLAG && !RESULT_VALID && !TRACE_VALID && !QUEUE_REFILL_REQUEST
            && (ACTIVITY_FLAGS == '0) && (FIRMWARE_OUTPUT_WORD == '0))
        else $error("Outputs not at defaults after reset");
    AST_IDLE: assert property (IDLE_FLAG == (st_q == nna_pkg::S_IDLE)) // R3
        else $error("Idle flag disagrees with state");
    AST_START: assert property (s_start |=> !IDLE_FLAG && QUEUE_REFILL_REQUEST) // R4
        else $error("Run request did not start execution");
    AST_CLEAR: assert property (s_start |=> (COMMAND_COUNT == '0) // R8
        && (DENSE_CYCLE_COUNT == '0) && (RUN_CYCLE_COUNT == '0))
        else $error("Counters not cleared on run");
    AST_FINISH: assert property (s_finish |=> IDLE_FLAG ##1 IDLE_FLAG || run) // R5
        else $error("Finish did not return to idle");
    AST_CYC: assert property (!IDLE_FLAG && !$past(IDLE_FLAG) // R7
        |-> RUN_CYCLE_COUNT == $past(RUN_CYCLE_COUNT) + `ONE32)
        else $error("Run cycle count did not advance");
    AST_DCYC: assert property ((st_q == nna_pkg::S_DENSE) // R9
        |=> DENSE_CYCLE_COUNT == $past(DENSE_CYCLE_COUNT) + `ONE32)
        else $error("Dense cycle count did not advance");
    AST_ACT: assert property ((ACTIVITY_FLAGS & ~`ACT_USED_MASK) == '0) // R6
        else $error("Reserved activity bits set");
    AST_WR: assert property (mem_we |=> mem[$past(INPUT_ADDR[MEM_AW-1:0])] // R13
        == $past(INPUT_DATA))
        else $error("Input write not retained");
    AST_EXCL: assert property (!(RESULT_VALID && TRACE_VALID)) // R25
        else $error("Result and trace valid together");
    AST_TRACE: assert property ($rose(TRACE_VALID) |-> $past(TRACE_READY, 2)) // R21
        else $error("Debug burst started without trace ready");
    // A reset taken on the attempt's first edge legally drops the request
    AST_REFILL: assert property (RSTN && QUEUE_REFILL_REQUEST |=> QUEUE_REFILL_REQUEST) // R15
        else $error("Refill request dropped outside reset");
endmodule

// ### dv/nna_queue_model.sv
`timescale 1ns/10ps
module nna_queue_model #(
    parameter int LOW_MARK = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic read_req,
    input wire logic slow,
    output logic empty,
    output logic low,
    output logic [31:0] word
);
    logic [31:0] store [0:255];
    logic [31:0] last_q;
    logic gap_q;
    int wr = 0;
    int rd = 0;
    task automatic load(input logic [31:0] w);
        store[wr[7:0]] = w;
        wr++;
    endtask
    always @(posedge clk) begin
        if (!rst_n) begin
            rd <= wr;
            gap_q <= 1'b0;
            last_q <= 32'h00000000;
        end else if (read_req && !empty) begin
            last_q <= word;
            rd <= rd + 1;
            gap_q <= slow;
        end else if (gap_q) begin
            gap_q <= 1'($urandom_range(0, 1));
        end
    end
    // While empty, the word shows the inverse of the last one released, so stale data never looks fresh
    assign empty = gap_q || (rd == wr);
    assign low = (wr - rd) < LOW_MARK;
    assign word = empty ? ~last_q : store[rd[7:0]];
endmodule

// ### dv/nna_host_if_tb.sv
`timescale 1ns/10ps
`include "nna_defines.svh"
module nna_host_if_tb;
    logic clk, rstn, run, idle, strobe, empty, low, rd_req, refill, rvld, tvld, tready, slow;
    logic [7:0] act, awaddr, araddr;
    logic [31:0] cyc, cmds, dense, fw, qword, rdata, wdata, v, fwv;
    logic [15:0] addr, data, rword;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, r;
    logic [3:0] wstrb;
    logic [15:0] exp_mem [int];
    logic [15:0] got[$];
    logic [15:0] tq[$];
    logic [31:0] prog[$];
    int failures, compares, cycles, busy_n, dense_n, conv_n;
    bit busy_wr;
    nna_host_if nna_host_if_inst (.REF_CLK(clk), .RSTN(rstn), .RUN_REQUEST(run),
        .IDLE_FLAG(idle), .ACTIVITY_FLAGS(act), .RUN_CYCLE_COUNT(cyc), .COMMAND_COUNT(cmds),
        .DENSE_CYCLE_COUNT(dense), .FIRMWARE_OUTPUT_WORD(fw), .INPUT_WRITE_STROBE(strobe),
        .INPUT_ADDR(addr), .INPUT_DATA(data), .QUEUE_REFILL_REQUEST(refill),
        .QUEUE_EMPTY_FLAG(empty), .QUEUE_LOW_FLAG(low), .QUEUE_READ_REQUEST(rd_req),
        .QUEUE_WORD(qword), .RESULT_VALID(rvld), .TRACE_VALID(tvld), .RESULT_WORD(rword),
        .TRACE_READY(tready), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    nna_queue_model nna_queue_model_inst (.clk(clk), .rst_n(rstn), .read_req(rd_req),
        .slow(slow), .empty(empty), .low(low), .word(qword));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] cmd(input logic [3:0] op, input logic [11:0] arg,
        input logic [15:0] len);
        return {op, arg, len};
    endfunction
    // Strobe is left up between calls so back-to-back writes never toggle it in one step
    task automatic mem_wr(input logic s, input logic [15:0] a, input logic [15:0] d);
        strobe <= s;
        addr <= a;
        data <= d;
        if (s && !busy_wr) exp_mem[a] = d;
        @(posedge clk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge clk);
        resp = bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        d = rdata;
        resp = rresp;
    endtask
    task automatic start_pins();
        run <= 1'b1;
        do @(posedge clk); while (idle);
        run <= 1'b0;
    endtask
    task automatic load_prog();
        foreach (prog[i]) nna_queue_model_inst.load(prog[i]);
        prog.delete();
    endtask
    always @(posedge clk) begin
        if (rstn) begin
            check({31'h0, rvld & tvld}, 32'h0);
            check({24'h0, act & 8'hFC}, 32'h0);
            if (!idle) busy_n++;
            if (act[1]) dense_n++;
            if (act[0]) conv_n++;
            if (rvld) got.push_back(rword);
            if (tvld) tq.push_back(rword);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        {rstn, run, strobe, tready, slow, awvalid, wvalid, arvalid} = 8'h00;
        {addr, data, awaddr, araddr, wdata, wstrb} = 84'h0;
        bready = 1'b1;
        rready = 1'b1;
        void'($urandom(64));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check({28'h0, idle, refill, rvld, tvld}, 32'h8);
        check(cyc | cmds | dense | fw | act, 32'h0);
        for (int i = 0; i < 4; i++) mem_wr(1'b1, 16'h0123 - 16'(i), 16'($urandom));
        for (int i = 0; i < 6; i++) mem_wr(1'b1, 16'h0120 + 16'($urandom_range(0, 3)), 16'($urandom));
        mem_wr(1'b0, 16'h0121, 16'($urandom));
        for (int i = 0; i < 2; i++) begin
            mem_wr(1'b1, 16'h0130 + 16'(i), {8'h00, 8'($urandom)});
        end
        strobe <= 1'b0;
        fwv = $urandom;
        prog = '{cmd(`OP_GPO, 0, 0), fwv, cmd(`OP_CONV, 0, 5), cmd(`OP_DENSE, 0, 3), $urandom,
            $urandom, $urandom, cmd(`OP_RESULT, 12'h012, 4), cmd(`OP_DEBUG, 12'h013, 2),
            cmd(`OP_NOP, 0, 0), cmd(4'h7, 0, 0), cmd(`OP_CONV, 0, 0), cmd(`OP_FINISH, 0, 0)};
        load_prog();
        busy_n = 0;
        start_pins();
        check(cyc | cmds | dense, 32'h0);
        check({31'h0, refill}, 32'h1);
        busy_wr = 1'b1;
        for (int i = 0; i < 4; i++) mem_wr(1'b1, 16'h0120 + 16'(i), 16'h5A5A);
        strobe <= 1'b0;
        busy_wr = 1'b0;
        while (got.size() < 4) @(posedge clk);
        repeat (20) @(posedge clk);
        check(tq.size(), 32'h0);
        tready <= 1'b1;
        while (!idle) @(posedge clk);
        @(posedge clk);
        check({31'h0, idle}, 32'h1);
        check(fw, fwv);
        check(cmds, 32'h9);
        check(cyc, busy_n);
        check(dense, dense_n);
        check({31'h0, dense_n >= 6}, 32'h1);
        check({31'h0, conv_n >= 5}, 32'h1);
        check(got.size(), 32'h4);
        check(tq.size(), 32'h2);
        for (int i = 0; i < 4; i++) check(got[i], exp_mem[16'h0120 + i]);
        for (int i = 0; i < 2; i++) check(tq[i], exp_mem[16'h0130 + i]);
        got.delete();
        slow <= 1'b1;
        prog = '{cmd(`OP_RESULT, 12'h012, 1), cmd(`OP_CONV, 0, 20), cmd(`OP_FINISH, 0, 0)};
        load_prog();
        busy_n = 0;
        axi_wr(`REG_CTRL, 32'h1, r);
        check(r, `RESP_OKAY);
        while (idle) @(posedge clk);
        axi_wr(`REG_CTRL, 32'h0, r);
        while (!idle) @(posedge clk);
        @(posedge clk);
        check(cmds, 32'h3);
        check(cyc, busy_n);
        check(got[0], exp_mem[16'h0120]);
        axi_rd(`REG_STAT, v, r);
        check(v, 32'h3);
        axi_rd(`REG_CMDS, v, r);
        check(v, 32'h3);
        axi_rd(`REG_GPO, v, r);
        check(v, fwv);
        axi_rd(8'h18, v, r);
        check(r, `RESP_SLVERR);
        axi_wr(`REG_CYC, 32'h5, r);
        check(r, `RESP_SLVERR);
        slow <= 1'b0;
        prog = '{cmd(`OP_CONV, 0, 40), cmd(`OP_FINISH, 0, 0)};
        load_prog();
        start_pins();
        repeat (3) @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check({28'h0, idle, refill, rvld, tvld}, 32'h8);
        check(cyc | cmds | dense | fw | act, 32'h0);
        wrap_up();
    end
endmodule
